//--- rtl/pfsd_strap_map.vh
`ifndef PFSD_STRAP_MAP_VH
`define PFSD_STRAP_MAP_VH

// Register byte offsets
`define PFSD_OFF_STRAP_STAT 8'h00
`define PFSD_OFF_PORT2_FLOW 8'h04
`define PFSD_OFF_PORT0_FLOW 8'h08
`define PFSD_OFF_PHY2_ADV 8'h0c
`define PFSD_OFF_VPHY_ADV 8'h10
`define PFSD_OFF_VPHY_PART 8'h14
`define PFSD_OFF_VPHY_SPEC 8'h18
`define PFSD_OFF_PORT0_STAT 8'h1c

// Strap vector bit positions
`define PFSD_S_FDFC2 0
`define PFSD_S_MANFC2 1
`define PFSD_S_SPEED0 2
`define PFSD_S_DUPPOL0 3
`define PFSD_S_BP0 4
`define PFSD_S_FDFC0 5
`define PFSD_S_MANFC0 6
`define PFSD_S_HBDIS 7
`define PFSD_STRAP_W 8
`define PFSD_STRAP_RST 8'h3d

// Advertisement and ability field positions
`define PFSD_F_10H 5
`define PFSD_F_10F 6
`define PFSD_F_100H 7
`define PFSD_F_100F 8
`define PFSD_F_PAUSE 10
`define PFSD_F_ASYM 11

// Port 0 mode codes
`define PFSD_MODE_MII_MAC 2'b00
`define PFSD_MODE_MII_PHY 2'b01
`define PFSD_MODE_RMII_PHY 2'b10

// AXI responses
`define PFSD_RESP_OKAY 2'b00
`define PFSD_RESP_SLVERR 2'b10

// Synchroniser depth before a pin counts
`define PFSD_SYNC_STAGES 3

`endif

//--- rtl/pfsd_pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module pfsd_pin_sync #(
    parameter WIDTH = 9
) (
    // Clock
    input wire clk_sys,
    // Pins
    input wire [WIDTH-1:0] pinIn,
    // Filtered levels
    output reg [WIDTH-1:0] stable_q
);

    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;
    integer i;

    // A bit changes only once stages two and three agree
    always @(posedge clk_sys) begin
        stage1_q <= pinIn;
        stage2_q <= stage1_q;
        stage3_q <= stage2_q;
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2_q[i] == stage3_q[i]) begin
                stable_q[i] <= stage3_q[i];
            end
        end
    end

endmodule // pfsd_pin_sync

`default_nettype wire

//--- rtl/pfsd_strap_latch.v
`timescale 1ns/1ps
`default_nettype none
`include "pfsd_strap_map.vh"

module pfsd_strap_latch (
    // Clock and reset
    input wire clk_sys,
    input wire srst,
    // Filtered strap pins
    input wire [`PFSD_STRAP_W-1:0] pinStraps,
    // Loader override
    input wire eepromValid,
    input wire [`PFSD_STRAP_W-1:0] eepromStraps,
    // Effective straps
    output reg [`PFSD_STRAP_W-1:0] straps_q,
    output reg apply_q
);

    reg inReset_q;

    always @(posedge clk_sys) begin
        if (srst) begin
            straps_q <= pinStraps; // R14
            inReset_q <= 1'b1;
            apply_q <= 1'b0;
        end else begin
            inReset_q <= 1'b0;
            apply_q <= inReset_q | eepromValid; // R14
            if (eepromValid) begin
                straps_q <= eepromStraps; // R13
            end
        end
    end

endmodule // pfsd_strap_latch

`default_nettype wire

//--- rtl/pfsd_strap_defaults.v
// Behaviour
// R01 - Port2 duplex-pause strap sets pause enables, asym
// R02 - Port2 manual strap sets select, pause advertisement
// R03 - Port0 speed strap sets partner speed abilities
// R04 - Failed virtual negotiation: port0 uses speed strap
// R05 - MII MAC: duplex pin polarity from strap
// R06 - Polarity strap also sets partner duplex abilities
// R07 - Port0 backpressure strap sets backpressure enable
// R08 - Port0 duplex-pause strap sets pause enables
// R09 - Same strap sets partner pause, asym bits
// R10 - Port0 manual strap sets select, virtual advertisement
// R11 - MAC mode ignores port0 manual strap
// R12 - Heartbeat strap acts in MII PHY only
// R13 - Loader may override soft strap values
// R14 - Straps load at reset; writes replace
`timescale 1ns/1ps
`default_nettype none
`include "pfsd_strap_map.vh"

module pfsd_strap_defaults #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input wire clk_sys,
    input wire srst,
    // Strap pins and port 0 duplex pin
    input wire [`PFSD_STRAP_W-1:0] strapPins,
    input wire port0DuplexInput,
    // Loader override
    input wire eepromValid,
    input wire [`PFSD_STRAP_W-1:0] eepromStraps,
    // Port 0 mode and negotiation status
    input wire [1:0] port0Mode,
    input wire virtualAnFail,
    input wire virtualAnSpeed100,
    input wire virtualAnFullDuplex,
    // AXI4-Lite write address
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Port flow-control bits: [0] tx pause, [1] rx pause, [2] manual select
    output reg [2:0] port2Flow_q,
    // [3] adds backpressure enable
    output reg [3:0] port0Flow_q,
    // Virtual PHY heartbeat off and port 0 operating state
    output reg heartbeatOff_q,
    output reg port0Speed100_q,
    output reg port0FullDuplex_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture

    wire [`PFSD_STRAP_W:0] pinSynced;
    wire [`PFSD_STRAP_W-1:0] straps;
    wire applyPulse;

    pfsd_pin_sync #(
        .WIDTH(`PFSD_STRAP_W + 1)
    ) u_sync (
        .clk_sys(clk_sys),
        .pinIn({port0DuplexInput, strapPins}),
        .stable_q(pinSynced)
    );

    pfsd_strap_latch u_latch (
        .clk_sys(clk_sys),
        .srst(srst),
        .pinStraps(pinSynced[`PFSD_STRAP_W-1:0]),
        .eepromValid(eepromValid),
        .eepromStraps(eepromStraps),
        .straps_q(straps),
        .apply_q(applyPulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Defaults derived from straps

    wire macMode = (port0Mode == `PFSD_MODE_MII_MAC);
    wire phyMode = (port0Mode == `PFSD_MODE_MII_PHY);
    wire fdFc2 = straps[`PFSD_S_FDFC2];
    wire manFc2 = straps[`PFSD_S_MANFC2];
    wire speed0 = straps[`PFSD_S_SPEED0];
    wire dupPol0 = straps[`PFSD_S_DUPPOL0];
    wire fdFc0 = straps[`PFSD_S_FDFC0];
    // Manual strap counts as low in MAC mode
    wire manFc0 = straps[`PFSD_S_MANFC0] & ~macMode; // R11

    wire [2:0] dfltPort2Flow = {manFc2, fdFc2, fdFc2}; // R01 R02
    wire [3:0] dfltPort0Flow = {straps[`PFSD_S_BP0], manFc0, fdFc0, fdFc0}; // R07 R08 R10
    // Advertisement fields: [0] symmetric pause, [1] asymmetric pause
    wire [1:0] dfltPhy2Adv = {fdFc2 & ~manFc2, fdFc2 & ~manFc2}; // R01 R02
    wire [1:0] dfltVphyAdv = {fdFc0 & ~manFc0, fdFc0 & ~manFc0}; // R10 R11
    // Partner fields: [3:0] 10H,10F,100H,100F, [4] pause, [5] asym
    wire [5:0] dfltVphyPart = {fdFc0, fdFc0, // R09
                               speed0 & dupPol0, speed0, // R03 R06
                               ~speed0 & dupPol0, ~speed0}; // R03 R06
    wire dfltHeartbeat = straps[`PFSD_S_HBDIS] & phyMode; // R12

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function [31:0] mergeStrobe;
        input [31:0] oldWord;
        input [31:0] newWord;
        input [3:0] strb;
        integer b;
        begin
            mergeStrobe = oldWord;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    mergeStrobe[b*8 +: 8] = newWord[b*8 +: 8];
                end
            end
        end
    endfunction

    function isMapped;
        input [7:0] addr;
        begin
            if (addr == `PFSD_OFF_STRAP_STAT) begin
                isMapped = 1'b1;
            end else if (addr == `PFSD_OFF_PORT2_FLOW) begin
                isMapped = 1'b1;
            end else if (addr == `PFSD_OFF_PORT0_FLOW) begin
                isMapped = 1'b1;
            end else if (addr == `PFSD_OFF_PHY2_ADV) begin
                isMapped = 1'b1;
            end else if (addr == `PFSD_OFF_VPHY_ADV) begin
                isMapped = 1'b1;
            end else if (addr == `PFSD_OFF_VPHY_PART) begin
                isMapped = 1'b1;
            end else if (addr == `PFSD_OFF_VPHY_SPEC) begin
                isMapped = 1'b1;
            end else if (addr == `PFSD_OFF_PORT0_STAT) begin
                isMapped = 1'b1;
            end else begin
                isMapped = 1'b0;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    reg [1:0] phy2Adv_q;
    reg [1:0] vphyAdv_q;
    reg [5:0] vphyPart_q;

    function [31:0] advWord;
        input [1:0] adv;
        begin
            advWord = 32'h0000_0000;
            advWord[`PFSD_F_PAUSE] = adv[0];
            advWord[`PFSD_F_ASYM] = adv[1];
        end
    endfunction

    function [31:0] readWord;
        input [7:0] addr;
        begin
            readWord = 32'h0000_0000;
            if (addr == `PFSD_OFF_STRAP_STAT) begin
                readWord[`PFSD_STRAP_W-1:0] = straps;
                readWord[9:8] = port0Mode;
            end else if (addr == `PFSD_OFF_PORT2_FLOW) begin
                readWord[2:0] = port2Flow_q;
            end else if (addr == `PFSD_OFF_PORT0_FLOW) begin
                readWord[3:0] = port0Flow_q;
            end else if (addr == `PFSD_OFF_PHY2_ADV) begin
                readWord = advWord(phy2Adv_q);
            end else if (addr == `PFSD_OFF_VPHY_ADV) begin
                readWord = advWord(vphyAdv_q);
            end else if (addr == `PFSD_OFF_VPHY_PART) begin
                readWord = advWord(vphyPart_q[5:4]);
                readWord[`PFSD_F_100F:`PFSD_F_10H] = vphyPart_q[3:0];
            end else if (addr == `PFSD_OFF_VPHY_SPEC) begin
                readWord[0] = heartbeatOff_q;
            end else if (addr == `PFSD_OFF_PORT0_STAT) begin
                readWord[0] = port0Speed100_q;
                readWord[1] = port0FullDuplex_q;
                readWord[2] = virtualAnFail;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    reg awHeld_q;
    reg [7:0] awAddr_q;
    reg wHeld_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;

    wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
    wire [31:0] wrSym = mergeStrobe(32'h0000_0000, wData_q, wStrb_q);

    always @(posedge clk_sys) begin
        if (srst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PFSD_RESP_OKAY;
        end else begin
            if (~awHeld_q & ~s_axi_bvalid & ~s_axi_awready) begin
                s_axi_awready <= 1'b1;
            end
            if (~wHeld_q & ~s_axi_bvalid & ~s_axi_wready) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid & s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr[7:0];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= isMapped(awAddr_q) ? `PFSD_RESP_OKAY : `PFSD_RESP_SLVERR;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    always @(posedge clk_sys) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PFSD_RESP_OKAY;
        end else begin
            if (~s_axi_rvalid & ~s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= readWord(s_axi_araddr[7:0]);
                s_axi_rresp <= isMapped(s_axi_araddr[7:0]) ? `PFSD_RESP_OKAY : `PFSD_RESP_SLVERR;
            end
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap-defaulted registers

    // Strap load wins over a write in the same cycle
    always @(posedge clk_sys) begin
        if (srst | applyPulse) begin
            port2Flow_q <= dfltPort2Flow; // R14
            port0Flow_q <= dfltPort0Flow; // R14
            phy2Adv_q <= dfltPhy2Adv;
            vphyAdv_q <= dfltVphyAdv;
            vphyPart_q <= dfltVphyPart;
            heartbeatOff_q <= dfltHeartbeat;
        end else if (doWrite) begin
            if (awAddr_q == `PFSD_OFF_PORT2_FLOW) begin
                port2Flow_q <= wrSym[2:0] | (port2Flow_q & ~{3{wStrb_q[0]}}); // R14
            end else if (awAddr_q == `PFSD_OFF_PORT0_FLOW) begin
                port0Flow_q <= wrSym[3:0] | (port0Flow_q & ~{4{wStrb_q[0]}}); // R14
            end else if (awAddr_q == `PFSD_OFF_PHY2_ADV) begin
                if (wStrb_q[1]) begin
                    phy2Adv_q <= {wrSym[`PFSD_F_ASYM], wrSym[`PFSD_F_PAUSE]};
                end
            end else if (awAddr_q == `PFSD_OFF_VPHY_ADV) begin
                if (wStrb_q[1]) begin
                    vphyAdv_q <= {wrSym[`PFSD_F_ASYM], wrSym[`PFSD_F_PAUSE]};
                end
            end else if (awAddr_q == `PFSD_OFF_VPHY_PART) begin
                if (wStrb_q[0]) begin
                    vphyPart_q[2:0] <= wrSym[`PFSD_F_100H:`PFSD_F_10H];
                end
                if (wStrb_q[1]) begin
                    vphyPart_q[5:3] <= {wrSym[`PFSD_F_ASYM], wrSym[`PFSD_F_PAUSE], wrSym[`PFSD_F_100F]};
                end
            end else if (awAddr_q == `PFSD_OFF_VPHY_SPEC) begin
                if (wStrb_q[0]) begin
                    heartbeatOff_q <= wrSym[0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port 0 speed and duplex

    // Pin active level equals polarity strap
    wire macDuplex = ~(pinSynced[`PFSD_STRAP_W] ^ dupPol0); // R05

    always @(posedge clk_sys) begin
        if (srst) begin
            port0Speed100_q <= 1'b0;
            port0FullDuplex_q <= 1'b0;
        end else begin
            port0Speed100_q <= virtualAnFail ? speed0 : virtualAnSpeed100; // R04
            port0FullDuplex_q <= macMode ? macDuplex : virtualAnFullDuplex; // R05
        end
    end

endmodule // pfsd_strap_defaults

`default_nettype wire

//--- rtl/_unused_placeholder_none.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- verif/pfsd_strap_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfsd_strap_map.vh"
////////////////////////////////////////////////////////////////////////////////
module pfsd_strap_checker #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Loader and status
    input wire logic eepromValid,
    input wire logic [7:0] eepromStraps,
    input wire logic [1:0] port0Mode,
    input wire logic virtualAnFail,
    input wire logic virtualAnSpeed100,
    input wire logic virtualAnFullDuplex,
    // Bus responses
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Flow and state outputs
    input wire logic [2:0] port2Flow_q,
    input wire logic [3:0] port0Flow_q,
    input wire logic heartbeatOff_q,
    input wire logic port0Speed100_q,
    input wire logic port0FullDuplex_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire macMode = (port0Mode == `PFSD_MODE_MII_MAC);

    a_p2_pause_load: assert property (eepromValid |-> ##2 port2Flow_q[1:0] == {2{$past(eepromStraps[0], 2)}})
        else $error("port2 pause enables not loaded");
    a_p2_manual_load: assert property (eepromValid |-> ##2 port2Flow_q[2] == $past(eepromStraps[1], 2))
        else $error("port2 manual select not loaded");
    a_p0_bp_load: assert property (eepromValid |-> ##2 port0Flow_q[3] == $past(eepromStraps[4], 2))
        else $error("port0 backpressure not loaded");
    a_p0_pause_load: assert property (eepromValid |-> ##2 port0Flow_q[1:0] == {2{$past(eepromStraps[5], 2)}})
        else $error("port0 pause enables not loaded");
    a_p0_manual_phy: assert property (eepromValid && !macMode |-> ##2 port0Flow_q[2] == $past(eepromStraps[6], 2))
        else $error("port0 manual select not loaded");
    a_p0_manual_mac: assert property (eepromValid && macMode |-> ##2 !port0Flow_q[2])
        else $error("port0 manual strap used in mac mode");
    a_hb_mode_gate: assert property (eepromValid |-> ##2 heartbeatOff_q == ($past(eepromStraps[7], 2)
        && $past(port0Mode, 2) == `PFSD_MODE_MII_PHY))
        else $error("heartbeat off default wrong");
    a_speed_track: assert property (!virtualAnFail |=> port0Speed100_q == $past(virtualAnSpeed100))
        else $error("port0 speed not from negotiation");
    a_duplex_virtual: assert property (!macMode |=> port0FullDuplex_q == $past(virtualAnFullDuplex))
        else $error("port0 duplex not from negotiation");
    a_bresp_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    a_rresp_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response held after handshake");

    c_loader: cover property (eepromValid ##2 port0Flow_q[2]);
    c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `PFSD_RESP_SLVERR);
    c_fail_speed: cover property (virtualAnFail && macMode);
endmodule // pfsd_strap_checker

bind pfsd_strap_defaults pfsd_strap_checker #(.ADDR_W(ADDR_W)) u_chk (.clk_sys, .srst, .eepromValid, .eepromStraps,
    .port0Mode, .virtualAnFail, .virtualAnSpeed100, .virtualAnFullDuplex, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .port2Flow_q, .port0Flow_q, .heartbeatOff_q,
    .port0Speed100_q, .port0FullDuplex_q);
`default_nettype wire

//--- verif/pfsd_strap_source.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfsd_strap_map.vh"
////////////////////////////////////////////////////////////////////////////////
module pfsd_strap_source (
    // Clock
    input wire logic clk_sys,
    // Strap pins and loader
    output var logic [7:0] strapPins,
    output var logic eepromValid,
    output var logic [7:0] eepromStraps
);
    initial begin
        strapPins = `PFSD_STRAP_RST;
        eepromValid = 1'b0;
        eepromStraps = 8'h00;
    end

    task automatic set_pins(input logic [7:0] v);
        @(posedge clk_sys);
        strapPins <= v;
    endtask

    // Value bus goes stale after the pulse
    task automatic load(input logic [7:0] v);
        @(posedge clk_sys);
        eepromValid <= 1'b1;
        eepromStraps <= v;
        @(posedge clk_sys);
        eepromValid <= 1'b0;
        eepromStraps <= ~v;
    endtask
endmodule // pfsd_strap_source
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfsd_strap_map.vh"
////////////////////////////////////////////////////////////////////////////////
module testbench;
    logic clk_sys = 1'b0, srst = 1'b1, port0DuplexInput = 1'b0;
    logic virtualAnFail = 1'b0, virtualAnSpeed100 = 1'b0, virtualAnFullDuplex = 1'b0;
    logic [1:0] port0Mode = `PFSD_MODE_MII_PHY;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] port2Flow_q;
    logic [3:0] port0Flow_q;
    logic heartbeatOff_q, port0Speed100_q, port0FullDuplex_q, eepromValid;
    logic [7:0] strapPins, eepromStraps;
    int error_cnt = 0, cmp_count = 0;

    always #12.5 clk_sys = ~clk_sys;

    pfsd_strap_source src (.clk_sys, .strapPins, .eepromValid, .eepromStraps);
    pfsd_strap_defaults #(.ADDR_W(8)) dut (.clk_sys, .srst, .strapPins, .port0DuplexInput, .eepromValid,
        .eepromStraps, .port0Mode, .virtualAnFail, .virtualAnSpeed100, .virtualAnFullDuplex, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .port2Flow_q, .port0Flow_q, .heartbeatOff_q, .port0Speed100_q, .port0FullDuplex_q);

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset;
        srst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge clk_sys);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Only the watchdog ends a stuck wait
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge clk_sys);
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge clk_sys);
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    // Compare every strap-defaulted register against straps s
    task automatic check_all(input logic [7:0] s);
        logic [31:0] d;
        logic [1:0] r;
        logic mac;
        mac = (port0Mode == `PFSD_MODE_MII_MAC);
        chk(port2Flow_q, {s[1], s[0], s[0]});
        chk(port0Flow_q, {s[4], s[6] & ~mac, s[5], s[5]});
        chk(heartbeatOff_q, s[7] & (port0Mode == `PFSD_MODE_MII_PHY));
        axi_rd(`PFSD_OFF_VPHY_PART, d, r);
        chk(d, {20'h0, s[5], s[5], 1'b0, s[2] & s[3], s[2], ~s[2] & s[3], ~s[2], 5'h0});
        axi_rd(`PFSD_OFF_VPHY_ADV, d, r);
        chk(d, {20'h0, {2{s[5] & ~(s[6] & ~mac)}}, 10'h0});
        axi_rd(`PFSD_OFF_PHY2_ADV, d, r);
        chk(d, {20'h0, {2{s[0] & ~s[1]}}, 10'h0});
        axi_rd(`PFSD_OFF_STRAP_STAT, d, r);
        chk(d, {22'h0, port0Mode, s});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_loader;
        logic [7:0] tbl [0:4];
        tbl = '{8'hff, 8'hc1, 8'h80, 8'h42, 8'h9c};
        for (int i = 0; i < 5; i++) begin
            port0Mode <= 2'(i % 3);
            repeat (3) @(posedge clk_sys);
            src.load(tbl[i]);
            repeat (3) @(posedge clk_sys);
            check_all(tbl[i]);
        end
        $display("test loader done");
    endtask

    task automatic t_speed_duplex;
        virtualAnFail <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(port0Speed100_q, 1'b1);
        src.load(8'h08);
        repeat (3) @(posedge clk_sys);
        chk(port0Speed100_q, 1'b0);
        virtualAnFail <= 1'b0;
        virtualAnSpeed100 <= 1'b1;
        virtualAnFullDuplex <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(port0Speed100_q, 1'b1);
        chk(port0FullDuplex_q, 1'b1);
        port0Mode <= `PFSD_MODE_MII_MAC;
        port0DuplexInput <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(port0FullDuplex_q, 1'b1);
        port0DuplexInput <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(port0FullDuplex_q, 1'b0);
        src.load(8'h00);
        repeat (8) @(posedge clk_sys);
        chk(port0FullDuplex_q, 1'b1);
        $display("test speed duplex done");
    endtask

    task automatic t_override;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`PFSD_OFF_PORT0_FLOW, 32'h5, r);
        chk(r, `PFSD_RESP_OKAY);
        chk(port0Flow_q, 4'h5);
        axi_rd(`PFSD_OFF_PORT0_FLOW, d, r);
        chk(d, 32'h5);
        // Lane 0 not strobed, so the flow bits must hold
        s_axi_wstrb <= 4'h2;
        axi_wr(`PFSD_OFF_PORT0_FLOW, 32'h0, r);
        s_axi_wstrb <= 4'hf;
        chk(port0Flow_q, 4'h5);
        axi_wr(8'h40, 32'hffff_ffff, r);
        chk(r, `PFSD_RESP_SLVERR);
        axi_rd(8'h40, d, r);
        chk(r, `PFSD_RESP_SLVERR);
        axi_wr(`PFSD_OFF_STRAP_STAT, 32'h0000_00ff, r);
        chk(r, `PFSD_RESP_OKAY);
        axi_rd(`PFSD_OFF_STRAP_STAT, d, r);
        chk(d, {22'h0, port0Mode, 8'h00});
        src.set_pins(8'ha6);
        do_reset();
        check_all(8'ha6);
        $display("test override done");
    endtask

    initial begin
        do_reset();
        check_all(`PFSD_STRAP_RST);
        $display("test defaults done");
        t_loader();
        t_speed_duplex();
        t_override();
        give_verdict();
    end

    initial begin
        #(25 * 5000);
        error_cnt++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
